//--- sfhc_top.sv
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// (RULE1) priority register three accepts byte, aligned halfword and word accesses
// (RULE2) tick [31:24], pend service [23:16], reserved [15:8], debug monitor [7:0]
// (RULE3) enables: usage [18], bus [17], protection [16], read/write
// (RULE4) pending bits [15:12] read 1 while each exception is pending
// (RULE5) pending set when entry began but a higher priority displaced it
// (RULE6) active bits [11],[10],[8],[7],[3],[1],[0] read 1 while active
// (RULE7) active while current or nested pre-empted exception
// (RULE8) usage [31:16], bus [15:8], protection [7:0], word/half/byte access
// (RULE9) write one clears a status bit, zero leaves it; reads show status
// (RULE10) protection bit 7 set when its fault address is valid
// (RULE11) protection bit 4 stacking, bit 3 unstacking derived fault
// (RULE12) data violation sets protection bit 1 and loads fault address
// (RULE13) fetch violation sets protection bit 0 only when issued
// (RULE14) bus bit 7 set when bus fault address is valid
// (RULE15) bus bit 4 stacking, bit 3 unstacking derived fault
// (RULE16) bus bit 2 imprecise, bit 1 precise with address capture
// (RULE17) bus bit 0 on prefetch error only if issued
// (RULE18) usage bit 9 on zero divisor when divide trap enabled
// (RULE19) usage bit 8 multi-word misaligned always, word/half when trap enabled
// (RULE20) usage bit 3 missing coprocessor, bit 2 bad return value
// (RULE21) usage bit 1 bad execution state, bit 0 undefined opcode
// (RULE22) usage status bits accumulate without clearing others
// (RULE23) divide trap enable config bit 4, misalign trap enable bit 3
// (RULE24) reserved bits read zero and ignore writes; the priority reserved byte [15:8] is stored and read back
module sfhc_top
  import sfhc_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   srst,
  // register port
  input  wire logic [31:0]            reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire sfhc_pkg::sfhc_size_e   reg_size,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic [31:0]                 reg_rdata,
  output logic                        reg_err,
  // exception state from the core, levels
  input  wire logic                   supervisor_call_pending_in,
  input  wire logic                   bus_error_pending_in,
  input  wire logic                   protection_pending_in,
  input  wire logic                   usage_error_pending_in,
  input  wire logic [6:0]             active_in,
  // fault events from the core, one-cycle pulses
  input  wire logic                   protection_stacking_error,
  input  wire logic                   protection_unstacking_error,
  input  wire logic                   data_access_violation,
  input  wire logic [31:0]            data_fault_addr,
  input  wire logic                   fetch_access_violation,
  input  wire logic                   fetch_issued,
  input  wire logic                   bus_stacking_error,
  input  wire logic                   bus_unstacking_error,
  input  wire logic                   imprecise_data_error,
  input  wire logic                   precise_data_error,
  input  wire logic [31:0]            bus_fault_addr_in,
  input  wire logic                   fetch_bus_error,
  input  wire logic                   divide_by_zero,
  input  wire logic                   multiword_misaligned,
  input  wire logic                   wordhalf_misaligned,
  input  wire logic                   missing_coprocessor_error,
  input  wire logic                   bad_return_value_error,
  input  wire logic                   bad_exec_state_error,
  input  wire logic                   undefined_opcode_error,
  // state shown to the core
  output logic [7:0]                  tick_priority,
  output logic [7:0]                  pend_service_priority,
  output logic [7:0]                  debug_monitor_priority,
  output logic                        usage_error_enable,
  output logic                        bus_error_enable,
  output logic                        protection_fault_enable,
  output logic                        zero_divide_trap_enable,
  output logic                        misalign_trap_enable,
  output logic [31:0]                 protection_fault_addr,
  output logic [31:0]                 bus_fault_addr
);
  import sfhc_pkg::*;

  logic [31:0] priority_ff;
  logic [31:0] control_ff;
  logic [31:0] fault_status_ff;
  logic [31:0] trap_config_ff;
  logic [31:0] prot_addr_ff;
  logic [31:0] bus_addr_ff;
  logic [31:0] reg_rdata_ff;
  logic        reg_err_ff;
  logic [31:0] nxt_fault_status;
  logic [31:0] fault_set;
  logic [31:0] fault_clr;
  logic [31:0] hw_state;

  // byte lane mask for an access, shifted by its byte offset
  function automatic logic [3:0] lane_mask(input sfhc_size_e sz, input logic [1:0] ofs);
    logic [3:0] base;
    base = 4'h1;
    case (sz)
      SFHC_SZ_BYTE: base = 4'h1;
      SFHC_SZ_HALF: base = 4'h3;
      SFHC_SZ_WORD: base = 4'hF;
      default:      base = 4'h0;
    endcase
    lane_mask = 4'((base << ofs));
  endfunction

  // access legal only when naturally aligned
  function automatic logic aligned(input sfhc_size_e sz, input logic [1:0] ofs);
    case (sz)
      SFHC_SZ_BYTE: aligned = 1'b1;
      SFHC_SZ_HALF: aligned = ~ofs[0];
      SFHC_SZ_WORD: aligned = (ofs == 2'b00);
      default:      aligned = 1'b0;
    endcase
  endfunction

  // expand lane mask to a bit mask
  function automatic logic [31:0] bit_mask(input logic [3:0] lanes);
    bit_mask = {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}};
  endfunction

  logic [31:0] word_addr;
  logic        acc_ok;
  logic [31:0] wmask;
  logic [31:0] wdata_lane;
  logic        hit_pri;
  logic        hit_ctl;
  logic        hit_fsr;
  logic        hit_cfg;

  // decode; the lone protection byte alias maps onto the packed word
  always_comb
  begin
    word_addr = {reg_addr[31:2], 2'b00};
    acc_ok    = aligned(reg_size, reg_addr[1:0]); // [RULE1] [RULE8]
    wmask     = bit_mask(lane_mask(reg_size, reg_addr[1:0]));
    wdata_lane = 32'((reg_wdata << {reg_addr[1:0], 3'b000}));
    hit_pri   = (word_addr == OFS_HANDLER_PRIORITY_THREE);
    hit_ctl   = (word_addr == OFS_HANDLER_CONTROL_STATE);
    hit_fsr   = (word_addr == OFS_PACKED_FAULT_STATUS)
              | (reg_addr == OFS_PROTECTION_FAULT_STATUS); // [RULE8]
    hit_cfg   = (word_addr == OFS_TRAP_CONFIG);
  end

  // priority register three, all four bytes stored
  always_ff @(posedge clk)
  begin
    if (srst)
      priority_ff <= RST_HANDLER_PRIORITY_THREE;
    else if (reg_wr && hit_pri && acc_ok)
      priority_ff <= (priority_ff & ~wmask) | (wdata_lane & wmask); // [RULE1] [RULE2]
  end

  // enables only; pending and active come from the core
  always_ff @(posedge clk)
  begin
    if (srst)
      control_ff <= RST_HANDLER_CONTROL_STATE;
    else if (reg_wr && hit_ctl && acc_ok)
      control_ff <= (control_ff & ~wmask) | (wdata_lane & wmask & 32'h00070000); // [RULE3]
  end

  // trap configuration bits
  always_ff @(posedge clk)
  begin
    if (srst)
      trap_config_ff <= RST_TRAP_CONFIG;
    else if (reg_wr && hit_cfg && acc_ok)
      trap_config_ff <= (trap_config_ff & ~wmask)
                      | (wdata_lane & wmask & MASK_TRAP_CONFIG); // [RULE23] [RULE24]
  end

  // live handler state as it reads
  always_comb
  begin
    hw_state = 32'h00000000;
    hw_state[POS_SUPERVISOR_CALL_PENDING] = supervisor_call_pending_in; // [RULE4] [RULE5]
    hw_state[POS_BUS_ERROR_PENDING]       = bus_error_pending_in;
    hw_state[POS_PROTECTION_PENDING]      = protection_pending_in;
    hw_state[POS_USAGE_ERROR_PENDING]     = usage_error_pending_in;
    hw_state[POS_TICK_ACTIVE]             = active_in[6]; // [RULE6] [RULE7]
    hw_state[POS_PEND_SERVICE_ACTIVE]     = active_in[5];
    hw_state[POS_DEBUG_MONITOR_ACTIVE]    = active_in[4];
    hw_state[POS_SUPERVISOR_CALL_ACTIVE]  = active_in[3];
    hw_state[POS_USAGE_ERROR_ACTIVE]      = active_in[2];
    hw_state[POS_BUS_ERROR_ACTIVE]        = active_in[1];
    hw_state[POS_PROTECTION_ACTIVE]       = active_in[0];
  end

  // fault events into set bits of the packed word
  always_comb
  begin
    fault_set = 32'h00000000;
    fault_set[POS_PROT_BYTE + POS_PROTECTION_ADDR_VALID]       = data_access_violation; // [RULE10]
    fault_set[POS_PROT_BYTE + POS_PROTECTION_STACKING_ERROR]   = protection_stacking_error; // [RULE11]
    fault_set[POS_PROT_BYTE + POS_PROTECTION_UNSTACKING_ERROR] = protection_unstacking_error;
    fault_set[POS_PROT_BYTE + POS_DATA_ACCESS_VIOLATION]       = data_access_violation; // [RULE12]
    fault_set[POS_PROT_BYTE + POS_FETCH_ACCESS_VIOLATION]      =
      fetch_access_violation & fetch_issued; // [RULE13]
    fault_set[POS_BUS_BYTE + POS_BUS_ADDR_VALID]       = precise_data_error; // [RULE14]
    fault_set[POS_BUS_BYTE + POS_BUS_STACKING_ERROR]   = bus_stacking_error; // [RULE15]
    fault_set[POS_BUS_BYTE + POS_BUS_UNSTACKING_ERROR] = bus_unstacking_error;
    fault_set[POS_BUS_BYTE + POS_IMPRECISE_DATA_ERROR] = imprecise_data_error; // [RULE16]
    fault_set[POS_BUS_BYTE + POS_PRECISE_DATA_ERROR]   = precise_data_error;
    fault_set[POS_BUS_BYTE + POS_FETCH_BUS_ERROR]      = fetch_bus_error & fetch_issued; // [RULE17]
    fault_set[POS_USAGE_HALF + POS_ZERO_DIVISOR_ERROR] =
      divide_by_zero & trap_config_ff[POS_ZERO_DIVIDE_TRAP_ENABLE]; // [RULE18] [RULE23]
    fault_set[POS_USAGE_HALF + POS_MISALIGNED_ERROR]   = multiword_misaligned
      | (wordhalf_misaligned & trap_config_ff[POS_MISALIGN_TRAP_ENABLE]); // [RULE19]
    fault_set[POS_USAGE_HALF + POS_MISSING_COPROCESSOR_ERROR] = missing_coprocessor_error; // [RULE20]
    fault_set[POS_USAGE_HALF + POS_BAD_RETURN_VALUE_ERROR]    = bad_return_value_error;
    fault_set[POS_USAGE_HALF + POS_BAD_EXEC_STATE_ERROR]      = bad_exec_state_error; // [RULE21]
    fault_set[POS_USAGE_HALF + POS_UNDEFINED_OPCODE_ERROR]    = undefined_opcode_error;
  end

  // write one to clear; a same-cycle event wins over the clear
  always_comb
  begin
    fault_clr = 32'h00000000;
    if (reg_wr && hit_fsr && acc_ok)
      fault_clr = wdata_lane & wmask & MASK_PACKED_FAULT_STATUS; // [RULE9]
    nxt_fault_status = ((fault_status_ff & ~fault_clr) | fault_set)
                     & MASK_PACKED_FAULT_STATUS; // [RULE22] [RULE24]
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      fault_status_ff <= RST_PACKED_FAULT_STATUS;
    else
      fault_status_ff <= nxt_fault_status;
  end

  // fault address capture
  always_ff @(posedge clk)
  begin
    if (srst)
      prot_addr_ff <= RST_FAULT_ADDR;
    else if (data_access_violation)
      prot_addr_ff <= data_fault_addr; // [RULE12]
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      bus_addr_ff <= RST_FAULT_ADDR;
    else if (precise_data_error)
      bus_addr_ff <= bus_fault_addr_in; // [RULE16]
  end

  // read data one cycle after the strobe, shifted to the low lanes
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      reg_rdata_ff <= 32'h00000000;
      reg_err_ff   <= 1'b0;
    end
    else
    begin
      reg_rdata_ff <= 32'h00000000;
      reg_err_ff   <= 1'b0;
      if (reg_rd || reg_wr)
        reg_err_ff <= ~acc_ok | ~(hit_pri | hit_ctl | hit_fsr | hit_cfg);
      if (reg_rd && acc_ok)
      begin
        if (hit_pri)
          reg_rdata_ff <= 32'(((priority_ff & wmask) >> {reg_addr[1:0], 3'b000}));
        else if (hit_ctl)
          reg_rdata_ff <= 32'((((control_ff | hw_state) & MASK_HANDLER_CONTROL_STATE & wmask)
                          >> {reg_addr[1:0], 3'b000})); // [RULE4] [RULE6] [RULE24]
        else if (hit_fsr)
          reg_rdata_ff <= 32'(((fault_status_ff & wmask) >> {reg_addr[1:0], 3'b000})); // [RULE9]
        else if (hit_cfg)
          reg_rdata_ff <= 32'(((trap_config_ff & wmask) >> {reg_addr[1:0], 3'b000}));
      end
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata               = reg_rdata_ff;
  assign reg_err                 = reg_err_ff;
  assign tick_priority           = priority_ff[POS_TICK_PRIORITY +: 8]; // [RULE2]
  assign pend_service_priority   = priority_ff[POS_PEND_SERVICE_PRIORITY +: 8];
  assign debug_monitor_priority  = priority_ff[POS_DEBUG_MONITOR_PRIORITY +: 8];
  assign usage_error_enable      = control_ff[POS_USAGE_ERROR_ENABLE];
  assign bus_error_enable        = control_ff[POS_BUS_ERROR_ENABLE];
  assign protection_fault_enable = control_ff[POS_PROTECTION_FAULT_ENABLE];
  assign zero_divide_trap_enable = trap_config_ff[POS_ZERO_DIVIDE_TRAP_ENABLE];
  assign misalign_trap_enable    = trap_config_ff[POS_MISALIGN_TRAP_ENABLE];
  assign protection_fault_addr   = prot_addr_ff;
  assign bus_fault_addr          = bus_addr_ff;
endmodule
`default_nettype wire

//--- sfhc_pkg.sv
package sfhc_pkg;
  // byte addresses of the register words (compared with the byte address, low two bits cleared)
  localparam int unsigned ADDR_W = 32;
  localparam logic [31:0] OFS_HANDLER_PRIORITY_THREE = 32'hE000ED20;
  localparam logic [31:0] OFS_HANDLER_CONTROL_STATE  = 32'hE000ED24;
  localparam logic [31:0] OFS_PACKED_FAULT_STATUS    = 32'hE000ED28;
  // byte aliases of the packed status word, kept as printed
  localparam logic [31:0] OFS_PROTECTION_FAULT_STATUS = 32'hE000D28;
  localparam logic [31:0] OFS_BUS_ERROR_STATUS        = 32'hE000ED29;
  localparam logic [31:0] OFS_USAGE_ERROR_STATUS      = 32'hE000ED2A;
  // own choice: trap enable configuration word
  localparam logic [31:0] OFS_TRAP_CONFIG            = 32'hE000ED14;

  // priority fields
  localparam int unsigned POS_TICK_PRIORITY          = 24;
  localparam int unsigned POS_PEND_SERVICE_PRIORITY  = 16;
  localparam int unsigned POS_RESERVED13_PRIORITY    = 8;
  localparam int unsigned POS_DEBUG_MONITOR_PRIORITY = 0;

  // handler control and state fields
  localparam int unsigned POS_USAGE_ERROR_ENABLE       = 18;
  localparam int unsigned POS_BUS_ERROR_ENABLE         = 17;
  localparam int unsigned POS_PROTECTION_FAULT_ENABLE  = 16;
  localparam int unsigned POS_SUPERVISOR_CALL_PENDING  = 15;
  localparam int unsigned POS_BUS_ERROR_PENDING        = 14;
  localparam int unsigned POS_PROTECTION_PENDING       = 13;
  localparam int unsigned POS_USAGE_ERROR_PENDING      = 12;
  localparam int unsigned POS_TICK_ACTIVE              = 11;
  localparam int unsigned POS_PEND_SERVICE_ACTIVE      = 10;
  localparam int unsigned POS_DEBUG_MONITOR_ACTIVE     = 8;
  localparam int unsigned POS_SUPERVISOR_CALL_ACTIVE   = 7;
  localparam int unsigned POS_USAGE_ERROR_ACTIVE       = 3;
  localparam int unsigned POS_BUS_ERROR_ACTIVE         = 1;
  localparam int unsigned POS_PROTECTION_ACTIVE        = 0;
  localparam logic [31:0] MASK_HANDLER_CONTROL_STATE   = 32'h0007FD8B;

  // packed fault status layout
  localparam int unsigned POS_PROT_BYTE  = 0;
  localparam int unsigned POS_BUS_BYTE   = 8;
  localparam int unsigned POS_USAGE_HALF = 16;
  localparam int unsigned POS_PROTECTION_ADDR_VALID       = 7;
  localparam int unsigned POS_PROTECTION_STACKING_ERROR   = 4;
  localparam int unsigned POS_PROTECTION_UNSTACKING_ERROR = 3;
  localparam int unsigned POS_DATA_ACCESS_VIOLATION       = 1;
  localparam int unsigned POS_FETCH_ACCESS_VIOLATION      = 0;
  localparam int unsigned POS_BUS_ADDR_VALID              = 7;
  localparam int unsigned POS_BUS_STACKING_ERROR          = 4;
  localparam int unsigned POS_BUS_UNSTACKING_ERROR        = 3;
  localparam int unsigned POS_IMPRECISE_DATA_ERROR        = 2;
  localparam int unsigned POS_PRECISE_DATA_ERROR          = 1;
  localparam int unsigned POS_FETCH_BUS_ERROR             = 0;
  localparam int unsigned POS_ZERO_DIVISOR_ERROR          = 9;
  localparam int unsigned POS_MISALIGNED_ERROR            = 8;
  localparam int unsigned POS_MISSING_COPROCESSOR_ERROR   = 3;
  localparam int unsigned POS_BAD_RETURN_VALUE_ERROR      = 2;
  localparam int unsigned POS_BAD_EXEC_STATE_ERROR        = 1;
  localparam int unsigned POS_UNDEFINED_OPCODE_ERROR      = 0;
  localparam logic [31:0] MASK_PACKED_FAULT_STATUS        = 32'h030F9F9B;

  // trap configuration fields
  localparam int unsigned POS_ZERO_DIVIDE_TRAP_ENABLE = 4;
  localparam int unsigned POS_MISALIGN_TRAP_ENABLE    = 3;
  localparam logic [31:0] MASK_TRAP_CONFIG            = 32'h00000018;

  // reset values
  localparam logic [31:0] RST_HANDLER_PRIORITY_THREE = 32'h00000000;
  localparam logic [31:0] RST_HANDLER_CONTROL_STATE  = 32'h00000000;
  localparam logic [31:0] RST_PACKED_FAULT_STATUS    = 32'h00000000;
  localparam logic [31:0] RST_TRAP_CONFIG            = 32'h00000000;
  localparam logic [31:0] RST_FAULT_ADDR             = 32'h00000000;

  // byte size codes of a bus access
  typedef enum logic [1:0]
  {
    SFHC_SZ_BYTE = 2'b00,
    SFHC_SZ_HALF = 2'b01,
    SFHC_SZ_WORD = 2'b10
  } sfhc_size_e;
endpackage

//--- sfhc_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sfhc_top_asserts
  import sfhc_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 srst,
  input wire logic [31:0]          reg_addr,
  input wire logic [31:0]          reg_wdata,
  input wire sfhc_pkg::sfhc_size_e reg_size,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire logic [31:0]          reg_rdata,
  input wire logic                 reg_err,
  input wire logic                 supervisor_call_pending_in,
  input wire logic                 bus_error_pending_in,
  input wire logic                 protection_pending_in,
  input wire logic                 usage_error_pending_in,
  input wire logic [6:0]           active_in,
  input wire logic                 data_access_violation,
  input wire logic [31:0]          data_fault_addr,
  input wire logic                 precise_data_error,
  input wire logic [31:0]          bus_fault_addr_in,
  input wire logic [7:0]           tick_priority,
  input wire logic [7:0]           pend_service_priority,
  input wire logic [7:0]           debug_monitor_priority,
  input wire logic                 usage_error_enable,
  input wire logic                 bus_error_enable,
  input wire logic                 protection_fault_enable,
  input wire logic                 zero_divide_trap_enable,
  input wire logic                 misalign_trap_enable,
  input wire logic [31:0]          protection_fault_addr,
  input wire logic [31:0]          bus_fault_addr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // word-sized strobes at the priority, control and trap configuration registers
  logic word_acc;
  logic prio_wr;
  logic ctrl_wr;
  logic ctrl_rd;
  logic trap_wr;
  assign word_acc = (reg_size == SFHC_SZ_WORD);
  assign prio_wr  = reg_wr && word_acc && (reg_addr == OFS_HANDLER_PRIORITY_THREE);
  assign ctrl_wr  = reg_wr && word_acc && (reg_addr == OFS_HANDLER_CONTROL_STATE);
  assign ctrl_rd  = reg_rd && word_acc && (reg_addr == OFS_HANDLER_CONTROL_STATE);
  assign trap_wr  = reg_wr && word_acc && (reg_addr == OFS_TRAP_CONFIG);
  // read data only in the answer cycle
  rd_idle_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside answer cycle");
  err_cause_a: assert property (reg_err |-> $past(reg_wr || reg_rd))
    else $error("error pulse without a strobe");
  misalign_err_a: assert property ((reg_wr || reg_rd) && (reg_addr[1:0] != 2'h0)
    && (word_acc || (reg_size == SFHC_SZ_HALF && reg_addr[0])) |=> reg_err)
    else $error("misaligned word access not refused");
  // register writes reach the outputs; tick and debug monitor priority outputs hold without a write
  prio_write_a: assert property (prio_wr |=> {tick_priority, pend_service_priority,
    debug_monitor_priority} == $past({reg_wdata[31:16], reg_wdata[7:0]}))
    else $error("priority fields not loaded");
  prio_hold_a: assert property
    (!reg_wr && !srst |=> $stable({tick_priority, debug_monitor_priority}))
    else $error("priority changed without a write");
  enable_write_a: assert property (ctrl_wr |=> {usage_error_enable, bus_error_enable,
    protection_fault_enable} == $past(reg_wdata[18:16]))
    else $error("fault enables not loaded");
  trap_write_a: assert property (trap_wr |=> {zero_divide_trap_enable, misalign_trap_enable}
    == $past(reg_wdata[4:3]))
    else $error("trap enables not loaded");
  // state bits follow the core; reserved control bits read zero
  pend_read_a: assert property (ctrl_rd |=> reg_rdata[15:12] == $past({supervisor_call_pending_in,
    bus_error_pending_in, protection_pending_in, usage_error_pending_in}))
    else $error("pending bits wrong");
  act_read_a: assert property (ctrl_rd |=> {reg_rdata[11:10], reg_rdata[8:7], reg_rdata[3],
    reg_rdata[1:0]} == $past(active_in))
    else $error("active bits wrong");
  ctrl_rsvd_a: assert property (ctrl_rd |=> (reg_rdata & ~MASK_HANDLER_CONTROL_STATE) == 32'h0)
    else $error("reserved control bits not zero");
  // fault address capture
  prot_addr_a: assert property (data_access_violation |=> protection_fault_addr == $past(data_fault_addr))
    else $error("protection fault address not captured");
  bus_addr_a: assert property (precise_data_error |=> bus_fault_addr == $past(bus_fault_addr_in))
    else $error("bus fault address not captured");
  cover property (reg_err);
  cover property (data_access_violation);
  cover property (ctrl_rd ##1 reg_rdata[15:12] != 4'h0);
endmodule
`default_nettype wire

//--- sfhc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin error_cnt++; $display("[ERR] %s exp %h got %h", nm, exp, got); end end
module test_sfhc_top;
  import sfhc_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [31:0] reg_addr = 32'h0;
  logic [31:0] reg_wdata = 32'h0;
  sfhc_size_e  reg_size = SFHC_SZ_WORD;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        reg_err;
  logic [3:0]  pend_v = 4'h0;
  logic [6:0]  act_v = 7'h0;
  logic [16:0] ev = 17'h0;
  logic [31:0] daddr = 32'h0;
  logic [31:0] baddr = 32'h0;
  logic [7:0]  tick_p, pend_p, dbg_p;
  logic        usg_en, bus_en, prot_en, div_trap, mis_trap;
  logic [31:0] prot_fa, bus_fa, got_data;
  logic        got_err;
  int          error_cnt = 0;
  int          samples_checked = 0;
  // event vector: stk,unstk,dviol,fviol,issued,bstk,bunstk,impr,prec,fbus,div0,mw,wh,missing_coprocessor_error,ret,st,undef
  sfhc_top u_sfhc_top (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_size(reg_size), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_err(reg_err),
    .supervisor_call_pending_in(pend_v[3]), .bus_error_pending_in(pend_v[2]),
    .protection_pending_in(pend_v[1]), .usage_error_pending_in(pend_v[0]), .active_in(act_v),
    .protection_stacking_error(ev[0]), .protection_unstacking_error(ev[1]),
    .data_access_violation(ev[2]), .data_fault_addr(daddr), .fetch_access_violation(ev[3]),
    .fetch_issued(ev[4]), .bus_stacking_error(ev[5]), .bus_unstacking_error(ev[6]),
    .imprecise_data_error(ev[7]), .precise_data_error(ev[8]), .bus_fault_addr_in(baddr),
    .fetch_bus_error(ev[9]), .divide_by_zero(ev[10]), .multiword_misaligned(ev[11]),
    .wordhalf_misaligned(ev[12]), .missing_coprocessor_error(ev[13]),
    .bad_return_value_error(ev[14]), .bad_exec_state_error(ev[15]),
    .undefined_opcode_error(ev[16]), .tick_priority(tick_p), .pend_service_priority(pend_p),
    .debug_monitor_priority(dbg_p), .usage_error_enable(usg_en), .bus_error_enable(bus_en),
    .protection_fault_enable(prot_en), .zero_divide_trap_enable(div_trap),
    .misalign_trap_enable(mis_trap), .protection_fault_addr(prot_fa), .bus_fault_addr(bus_fa));
  always #5 clk = ~clk;
  task automatic finish_test();
    if (error_cnt == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one strobe, answer sampled in the cycle after
  task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d, input sfhc_size_e s);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= ~w;
    reg_addr <= a;
    reg_wdata <= d;
    reg_size <= s;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    got_data = reg_rdata;
    got_err = reg_err;
  endtask
  task automatic rd(input logic [31:0] a, input sfhc_size_e s, input logic [31:0] exp, input string nm);
    acc(1'b0, a, 32'h0, s);
    `CHK(nm, exp, got_data)
    `CHK("rd_err", 1'b0, got_err)
  endtask
  // one-cycle fault event pulse
  task automatic pulse(input logic [16:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 17'h0;
  endtask
  task automatic s_priority();
    acc(1'b1, OFS_HANDLER_PRIORITY_THREE, 32'hA1B2C3D4, SFHC_SZ_WORD);
    rd(OFS_HANDLER_PRIORITY_THREE, SFHC_SZ_WORD, 32'hA1B2C3D4, "prio_word");
    `CHK("prio_out", 24'hA1B2D4, {tick_p, pend_p, dbg_p})
    acc(1'b1, 32'hE000ED23, 32'h5E, SFHC_SZ_BYTE);
    acc(1'b1, OFS_HANDLER_PRIORITY_THREE, 32'h1234, SFHC_SZ_HALF);
    rd(OFS_HANDLER_PRIORITY_THREE, SFHC_SZ_WORD, 32'h5EB21234, "prio_mix");
    rd(32'hE000ED22, SFHC_SZ_HALF, 32'h5EB2, "prio_half");
    rd(32'hE000ED21, SFHC_SZ_BYTE, 32'h12, "prio_byte");
    acc(1'b1, 32'hE000ED21, 32'hFFFF, SFHC_SZ_HALF);
    `CHK("misalign_err", 1'b1, got_err)
    rd(OFS_HANDLER_PRIORITY_THREE, SFHC_SZ_WORD, 32'h5EB21234, "prio_kept");
    acc(1'b0, 32'hE000ED30, 32'h0, SFHC_SZ_WORD);
    `CHK("unmapped", 33'h100000000, {got_err, got_data})
  endtask
  task automatic s_control();
    acc(1'b1, OFS_HANDLER_CONTROL_STATE, 32'hFFFFFFFF, SFHC_SZ_WORD);
    pend_v <= 4'hA;
    act_v <= 7'h55;
    rd(OFS_HANDLER_CONTROL_STATE, SFHC_SZ_WORD, 32'h0007A909, "ctrl_a");
    `CHK("enables", 3'h7, {usg_en, bus_en, prot_en})
    acc(1'b1, OFS_HANDLER_CONTROL_STATE, 32'h0, SFHC_SZ_WORD);
    pend_v <= 4'h5;
    act_v <= 7'h2A;
    rd(OFS_HANDLER_CONTROL_STATE, SFHC_SZ_WORD, 32'h00005482, "ctrl_b");
    pend_v <= 4'h0;
    act_v <= 7'h0;
  endtask
  task automatic s_faults();
    pulse(17'h01608); // fetch faults not issued, traps off
    pulse(17'h00008);
    rd(OFS_PACKED_FAULT_STATUS, SFHC_SZ_WORD, 32'h0, "gated");
    daddr <= 32'h2000_0F04;
    baddr <= 32'h4000_1002;
    pulse(17'h00007);
    pulse(17'h00018);
    pulse(17'h003F0);
    rd(OFS_PACKED_FAULT_STATUS, SFHC_SZ_WORD, 32'h00009F9B, "prot_bus");
    `CHK("fault_addrs", 64'h20000F0440001002, {prot_fa, bus_fa})
    pulse(17'h00800);
    pulse(17'h1E000);
    rd(OFS_USAGE_ERROR_STATUS, SFHC_SZ_HALF, 32'h010F, "usage");
    acc(1'b1, OFS_TRAP_CONFIG, 32'hFFFFFFFF, SFHC_SZ_WORD);
    rd(OFS_TRAP_CONFIG, SFHC_SZ_WORD, 32'h18, "trap_cfg");
    pulse(17'h01400);
    rd(OFS_PACKED_FAULT_STATUS, SFHC_SZ_WORD, 32'h030F9F9B, "all");
  endtask
  task automatic s_clear();
    acc(1'b1, OFS_PACKED_FAULT_STATUS, 32'h0, SFHC_SZ_WORD);
    rd(OFS_PACKED_FAULT_STATUS, SFHC_SZ_WORD, 32'h030F9F9B, "zero_wr");
    acc(1'b1, OFS_BUS_ERROR_STATUS, 32'h81, SFHC_SZ_BYTE);
    acc(1'b1, OFS_USAGE_ERROR_STATUS, 32'h0200, SFHC_SZ_HALF);
    acc(1'b1, OFS_PACKED_FAULT_STATUS, 32'h2, SFHC_SZ_WORD);
    rd(OFS_PACKED_FAULT_STATUS, SFHC_SZ_WORD, 32'h010F1E99, "cleared");
    rd(OFS_PROTECTION_FAULT_STATUS, SFHC_SZ_BYTE, 32'h99, "prot_byte");
    rd(OFS_BUS_ERROR_STATUS, SFHC_SZ_BYTE, 32'h1E, "bus_byte");
  endtask
  task automatic s_mid_reset();
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    rd(OFS_HANDLER_PRIORITY_THREE, SFHC_SZ_WORD, 32'h0, "rst_prio");
    rd(OFS_PACKED_FAULT_STATUS, SFHC_SZ_WORD, 32'h0, "rst_status");
    `CHK("rst_traps", 2'h0, {div_trap, mis_trap})
    `CHK("rst_addrs", 64'h0, {prot_fa, bus_fa})
  endtask
  // run cut short if the sequence hangs
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    finish_test();
  end
  initial
  begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rd(OFS_PACKED_FAULT_STATUS, SFHC_SZ_WORD, 32'h0, "rst_configurable_fault_status");
    s_priority();
    s_control();
    s_faults();
    s_clear();
    s_mid_reset();
    finish_test();
  end
endmodule
bind sfhc_top sfhc_top_asserts u_sfhc_top_asserts (.clk, .srst, .reg_addr, .reg_wdata,
  .reg_size, .reg_wr, .reg_rd, .reg_rdata, .reg_err, .supervisor_call_pending_in,
  .bus_error_pending_in, .protection_pending_in, .usage_error_pending_in, .active_in,
  .data_access_violation, .data_fault_addr, .precise_data_error, .bus_fault_addr_in,
  .tick_priority, .pend_service_priority, .debug_monitor_priority, .usage_error_enable,
  .bus_error_enable, .protection_fault_enable, .zero_divide_trap_enable,
  .misalign_trap_enable, .protection_fault_addr, .bus_fault_addr);
`default_nettype wire
